// ===== pkg/adcc_pkg.sv
// Constants shared by the converter control block and its sub-modules
package adcc_pkg;
    // Register byte addresses on the Wishbone slave
    localparam logic [3:0] ADDR_CSR      = 4'h0;
    localparam logic [3:0] ADDR_RES_HI   = 4'h4;
    localparam logic [3:0] ADDR_RES_LO   = 4'h8;
    // Field positions
    localparam int         CSR_EOC_BIT   = 7;
    localparam int         CSR_SPEED_BIT = 6;
    localparam int         CSR_CONVERTER_POWER_ON_BIT  = 5;
    localparam int         CSR_CH_LSB    = 0;
    localparam int         LO_SLOW_BIT   = 3;
    // Values after reset
    localparam logic [7:0] CSR_RESET     = 8'h00;
    localparam logic [9:0] RESULT_RESET  = 10'h000;
    // Result width and trial code
    localparam int         RESULT_BITS   = 10;
    localparam logic [9:0] MSB_TRIAL     = 10'h200;
    localparam logic [3:0] MSB_INDEX     = 4'h9;
    // Last count of the converter clock divider
    localparam logic [1:0] DIV_FULL_LAST    = 2'h0;
    localparam logic [1:0] DIV_HALF_LAST    = 2'h1;
    localparam logic [1:0] DIV_QUARTER_LAST = 2'h3;
    // Converter clock ticks per phase
    localparam logic [2:0] SAMPLE_TICKS  = 3'h3;
    localparam logic [2:0] TRIAL_TICKS   = 3'h6;
    // Settling after halt, least time
    localparam int         CLK_PERIOD_NS      = 10;
    localparam int         WAKE_SETTLE_NS     = 1000;
    localparam int         WAKE_SETTLE_CYCLES = (WAKE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int         SETTLE_W           = $clog2(WAKE_SETTLE_CYCLES + 1);
    localparam logic [SETTLE_W-1:0] SETTLE_LOAD = SETTLE_W'(WAKE_SETTLE_CYCLES);
endpackage : adcc_pkg

// ===== pkg/adcc_conv_if.sv
// Carrier between control registers, clock divider and approximation engine
`timescale 1ns/1ps
interface adcc_conv_if;
    logic       slow;
    logic       speed;
    logic       run;
    logic       tick;
    logic       comp;
    logic       busy;
    logic       done;
    logic       sample;
    logic [9:0] code;
    logic [9:0] result;

    modport ctl (output slow, speed, run, comp, input tick, busy, done, sample, code, result);
    modport div (input slow, speed, run, output tick);
    modport sar (input tick, run, comp, output busy, done, sample, code, result);
endinterface : adcc_conv_if

// ===== logic/adcc_clk_div.sv
// Converter clock enable generator
`timescale 1ns/1ps
module adcc_clk_div (
    input  wire logic clk_i,
    input  wire logic rst_i,
    adcc_conv_if.div  cv
);
    typedef struct packed {
        logic [1:0] cnt;
        logic       tick;
    } adcc_div_state_t;

    adcc_div_state_t st_reg;
    adcc_div_state_t st_next;

    always_comb begin
        logic [1:0] last_cnt;
        last_cnt = adcc_pkg::DIV_HALF_LAST;
        st_next  = st_reg;
        if (cv.slow) begin
            last_cnt = adcc_pkg::DIV_QUARTER_LAST;
        end else if (cv.speed) begin
            last_cnt = adcc_pkg::DIV_FULL_LAST;
        end
        if (!cv.run) begin
            st_next.cnt  = 2'h0;
            st_next.tick = 1'b0;
        end else if (st_reg.cnt >= last_cnt) begin
            st_next.cnt  = 2'h0;
            st_next.tick = 1'b1;
        end else begin
            st_next.cnt  = st_reg.cnt + 2'h1;
            st_next.tick = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign cv.tick = st_reg.tick;
endmodule : adcc_clk_div

// ===== logic/adcc_sar.sv
// Successive approximation sequencer, repeating while enabled
`timescale 1ns/1ps
module adcc_sar (
    input  wire logic clk_i,
    input  wire logic rst_i,
    adcc_conv_if.sar  cv
);
    typedef enum logic [1:0] {SAR_IDLE, SAR_SAMPLE, SAR_TRIAL} adcc_sar_phase_t;

    typedef struct packed {
        adcc_sar_phase_t phase;
        logic [3:0]      bit_idx;
        logic [2:0]      wait_cnt;
        logic [9:0]      code;
        logic [9:0]      result;
        logic            done;
    } adcc_sar_state_t;

    adcc_sar_state_t st_reg;
    adcc_sar_state_t st_next;

    always_comb begin
        logic [9:0] kept;
        kept         = st_reg.code;
        st_next      = st_reg;
        st_next.done = 1'b0;
        if (!cv.run) begin
            st_next.phase    = SAR_IDLE;
            st_next.code     = 10'h000;
            st_next.wait_cnt = 3'h0;
        end else if (cv.tick) begin
            case (st_reg.phase)
                SAR_IDLE: begin
                    st_next.phase    = SAR_SAMPLE;
                    st_next.wait_cnt = 3'h0;
                end
                SAR_SAMPLE: begin
                    if (st_reg.wait_cnt == adcc_pkg::SAMPLE_TICKS - 3'h1) begin
                        st_next.phase    = SAR_TRIAL;
                        st_next.bit_idx  = adcc_pkg::MSB_INDEX;
                        st_next.code     = adcc_pkg::MSB_TRIAL;
                        st_next.wait_cnt = 3'h0;
                    end else begin
                        st_next.wait_cnt = st_reg.wait_cnt + 3'h1;
                    end
                end
                SAR_TRIAL: begin
                    if (st_reg.wait_cnt == adcc_pkg::TRIAL_TICKS - 3'h1) begin
                        // Input above every trial gives 3FF, below every trial 000
                        if (!cv.comp) begin
                            kept[st_reg.bit_idx] = 1'b0;
                        end
                        st_next.wait_cnt = 3'h0;
                        if (st_reg.bit_idx == 4'h0) begin
                            st_next.result = kept;
                            st_next.done   = 1'b1;
                            st_next.phase  = SAR_SAMPLE;
                            st_next.code   = 10'h000;
                        end else begin
                            kept[st_reg.bit_idx - 4'h1] = 1'b1;
                            st_next.code    = kept;
                            st_next.bit_idx = st_reg.bit_idx - 4'h1;
                        end
                    end else begin
                        st_next.wait_cnt = st_reg.wait_cnt + 3'h1;
                    end
                end
                default: begin
                    st_next.phase = SAR_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign cv.busy   = st_reg.phase != SAR_IDLE;
    assign cv.sample = st_reg.phase == SAR_SAMPLE;
    assign cv.done   = st_reg.done;
    assign cv.code   = st_reg.code;
    assign cv.result = st_reg.result;
endmodule : adcc_sar

// ===== logic/adcc_top.sv
// Converter control: Wishbone registers, comparator input, power and halt handling
//
// What this block does
// - Input above high reference reads FFh and 03h
// - Input below low reference reads zero
// - Setting power-on bit starts converting selected channel
// - Conversions repeat back to back while on
// - Each conversion stores result, sets end flag
// - Only reading result high byte clears flag
// - Channel field bits 2:0 select inputs 0-6
// - Clearing bit 5 powers converter off
// - Wait mode leaves converter running
// - Halt disables converter; settle after wake-up
// - High byte read-only, holds result bits 9:2
// - Low byte bits 1:0 hold result bits 1:0
// - Reserved bits read zero, kept clear
// - Clock: /2, undivided, or /4 by slow
// - Reset clears whole control/status register
`timescale 1ns/1ps
module adcc_top (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output wire logic [31:0] wb_dat_o,
    output wire logic        wb_ack_o,
    input  wire logic        halt_i,
    input  wire logic        comparator_i,
    output wire logic        converter_power_on_o,
    output wire logic        sample_hold_o,
    output wire logic [9:0]  dac_code_o,
    output wire logic [2:0]  input_channel_select_o
);

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic                          ack;
        logic [7:0]                    rdata;
        logic                          eoc;
        logic                          speed;
        logic                          converter_power_on;
        logic [2:0]                    chan;
        logic                          slow;
        logic [9:0]                    result;
        logic [2:0]                    comp_sync;
        logic                          comp_filt;
        logic [adcc_pkg::SETTLE_W-1:0] settle_cnt;
    } adcc_top_state_t;

    adcc_top_state_t st_reg;
    adcc_top_state_t st_next;

    adcc_conv_if cv ();

    logic       bus_req;
    logic       rd_hi;
    logic       rd_lo;
    logic       wr_csr;
    logic       wr_lo;
    logic [7:0] csr_view;
    logic [7:0] lo_view;
    logic [7:0] result_hi;
    logic [1:0] result_lo;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Bus decode

    // One ack per take; ack blocks a new take only in the cycle it is high, so a stb still held is taken again
    assign bus_req = wb_cyc_i & wb_stb_i & ~st_reg.ack;
    assign rd_hi   = bus_req & ~wb_we_i & (wb_adr_i == adcc_pkg::ADDR_RES_HI);
    assign rd_lo   = bus_req & ~wb_we_i & (wb_adr_i == adcc_pkg::ADDR_RES_LO);
    assign wr_csr  = bus_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == adcc_pkg::ADDR_CSR);
    assign wr_lo   = bus_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == adcc_pkg::ADDR_RES_LO);

    assign result_hi = st_reg.result[9:2];
    assign result_lo = st_reg.result[1:0];

    // Bits 4:3 always read zero
    assign csr_view = {st_reg.eoc, st_reg.speed, st_reg.converter_power_on, 2'b00, st_reg.chan};
    // Bits 7:4 and 2 always read zero
    assign lo_view  = {4'h0, st_reg.slow, 1'b0, result_lo};

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        st_next     = st_reg;
        st_next.ack = bus_req;

        // Read data is captured at the take, before any flag clear of the same edge
        if (bus_req & ~wb_we_i) begin
            case (wb_adr_i)
                adcc_pkg::ADDR_CSR:    st_next.rdata = csr_view;
                adcc_pkg::ADDR_RES_HI: st_next.rdata = result_hi;
                adcc_pkg::ADDR_RES_LO: st_next.rdata = lo_view;
                default:               st_next.rdata = 8'h00;
            endcase
        end

        // End flag is not writable; reserved bits are not stored
        if (wr_csr) begin
            st_next.speed = wb_dat_i[adcc_pkg::CSR_SPEED_BIT];
            st_next.converter_power_on  = wb_dat_i[adcc_pkg::CSR_CONVERTER_POWER_ON_BIT];
            st_next.chan  = wb_dat_i[adcc_pkg::CSR_CH_LSB +: 3];
        end
        if (wr_lo) begin
            st_next.slow = wb_dat_i[adcc_pkg::LO_SLOW_BIT];
        end

        // Completion is visible only through this polled flag
        if (rd_hi) begin
            st_next.eoc = 1'b0;
        end
        // A completion in the same cycle as the clearing read wins
        if (cv.done) begin
            st_next.eoc    = 1'b1;
            st_next.result = cv.result;
        end

        // Comparator: a change counts once the second and third stage agree
        st_next.comp_sync = {st_reg.comp_sync[1:0], comparator_i};
        if (st_reg.comp_sync[1] == st_reg.comp_sync[2]) begin
            st_next.comp_filt = st_reg.comp_sync[2];
        end

        // Halt reloads the settle count; conversions wait it out after wake-up
        if (halt_i) begin
            st_next.settle_cnt = adcc_pkg::SETTLE_LOAD;
        end else if (st_reg.settle_cnt != '0) begin
            st_next.settle_cnt = st_reg.settle_cnt - 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg       <= '0;
            st_reg.eoc   <= adcc_pkg::CSR_RESET[adcc_pkg::CSR_EOC_BIT];
            st_reg.speed <= adcc_pkg::CSR_RESET[adcc_pkg::CSR_SPEED_BIT];
            st_reg.converter_power_on  <= adcc_pkg::CSR_RESET[adcc_pkg::CSR_CONVERTER_POWER_ON_BIT];
            st_reg.chan  <= adcc_pkg::CSR_RESET[adcc_pkg::CSR_CH_LSB +: 3];
            st_reg.result <= adcc_pkg::RESULT_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Converter engine

    // Wait mode is deliberately not a term: the converter keeps running there
    assign cv.run   = st_reg.converter_power_on & ~halt_i & (st_reg.settle_cnt == '0);
    assign cv.slow  = st_reg.slow;
    assign cv.speed = st_reg.speed;
    assign cv.comp  = st_reg.comp_filt;

    adcc_clk_div u_div (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .cv    (cv.div)
    );

    adcc_sar u_sar (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .cv    (cv.sar)
    );

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign wb_dat_o               = {24'h000000, st_reg.rdata};
    assign wb_ack_o               = st_reg.ack;
    // Analog stays powered while settling so the reference can stabilise
    assign converter_power_on_o   = st_reg.converter_power_on & ~halt_i;
    assign sample_hold_o          = cv.sample;
    assign dac_code_o             = cv.code;
    assign input_channel_select_o = st_reg.chan;

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Assertions

    sequence s_switch_on;
        $rose(cv.run);
    endsequence

    sequence s_sampling;
        ##[1:8] cv.sample;
    endsequence

    property p_start_sampling;
        @(posedge clk_i) disable iff (rst_i)
        s_switch_on |-> s_sampling;
    endproperty

    sequence s_halt_entry;
        halt_i && !converter_power_on_o;
    endsequence

    sequence s_engine_idle;
        ##1 !cv.busy;
    endsequence

    property p_halt_stops;
        @(posedge clk_i) disable iff (rst_i)
        halt_i |-> s_halt_entry and s_engine_idle;
    endproperty

    sequence s_quarter_tick;
        cv.tick && cv.slow && cv.run;
    endsequence

    sequence s_quarter_hold;
        (cv.slow && cv.run) [*3];
    endsequence

    // Divider restarts at zero on each tick, so the fourth cycle after it ticks again
    property p_quarter_period;
        @(posedge clk_i) disable iff (rst_i)
        s_quarter_tick ##1 s_quarter_hold |=> cv.tick;
    endproperty

    a_bus_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    a_eoc_read_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        (rd_hi && !cv.done) |=> !st_reg.eoc)
        else $error("end flag not cleared by high byte read");

    a_eoc_only_hi: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(st_reg.eoc) |-> $past(rd_hi))
        else $error("end flag cleared without high byte read");

    a_eoc_done_set: assert property (@(posedge clk_i) disable iff (rst_i)
        cv.done |=> st_reg.eoc && (st_reg.result == $past(cv.result)))
        else $error("completion did not store result and set flag");

    a_result_overwrite: assert property (@(posedge clk_i) disable iff (rst_i)
        (cv.done && st_reg.eoc && !rd_hi) |=> st_reg.eoc && (st_reg.result == $past(cv.result)))
        else $error("unread result not overwritten");

    a_hi_read_layout: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(rd_hi) |-> wb_ack_o && (wb_dat_o == {24'h000000, $past(result_hi)}))
        else $error("high byte read returned wrong bits");

    a_lo_read_layout: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(rd_lo) |-> (wb_dat_o[7:4] == 4'h0) && !wb_dat_o[2] && (wb_dat_o[1:0] == $past(result_lo)))
        else $error("low byte read returned wrong bits");

    a_off_stops: assert property (@(posedge clk_i) disable iff (rst_i)
        !st_reg.converter_power_on |-> !converter_power_on_o ##1 !cv.busy)
        else $error("converter still active after power-off");

    a_halt_stops: assert property (p_halt_stops)
        else $error("converter not disabled in halt");

    a_halt_settle: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(halt_i) |-> !cv.run [*8])
        else $error("conversion restarted before settling");

    a_start_sample: assert property (p_start_sampling)
        else $error("switch-on did not start sampling");

    a_auto_repeat: assert property (@(posedge clk_i) disable iff (rst_i)
        (cv.done && $past(cv.run)) |-> cv.sample)
        else $error("conversion did not repeat");

    a_csr_reset: assert property (@(posedge clk_i)
        $fell(rst_i) |-> (csr_view == adcc_pkg::CSR_RESET))
        else $error("control register not cleared by reset");

    a_flag_ro_write: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr_csr && !cv.done) |=> $stable(st_reg.eoc))
        else $error("end flag changed by a register write");

    a_hi_no_write: assert property (@(posedge clk_i) disable iff (rst_i)
        (bus_req && wb_we_i && (wb_adr_i == adcc_pkg::ADDR_RES_HI) && !cv.done)
        |=> $stable(st_reg.result) && $stable(st_reg.eoc))
        else $error("write to high byte changed state");

    a_chan_write: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_csr |=> (input_channel_select_o == $past(wb_dat_i[adcc_pkg::CSR_CH_LSB +: 3])))
        else $error("channel field not taken from write");

    a_power_write: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_csr |=> (st_reg.converter_power_on == $past(wb_dat_i[adcc_pkg::CSR_CONVERTER_POWER_ON_BIT])))
        else $error("power-on bit not taken from write");

    a_slow_write: assert property (@(posedge clk_i) disable iff (rst_i)
        wr_lo |=> (cv.slow == $past(wb_dat_i[adcc_pkg::LO_SLOW_BIT])))
        else $error("slow bit not taken from write");

    a_done_needs_run: assert property (@(posedge clk_i) disable iff (rst_i)
        !cv.run |=> !cv.done)
        else $error("completion while converter stopped");

    a_dac_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        !cv.busy |-> (dac_code_o == 10'h000))
        else $error("trial code left driven while idle");

    a_settle_load: assert property (@(posedge clk_i) disable iff (rst_i)
        halt_i |=> (st_reg.settle_cnt == adcc_pkg::SETTLE_LOAD))
        else $error("settle count not reloaded in halt");

    a_comp_filter: assert property (@(posedge clk_i) disable iff (rst_i)
        $changed(st_reg.comp_filt) |-> $past(st_reg.comp_sync[1] == st_reg.comp_sync[2]))
        else $error("comparator accepted before stages agreed");

    a_ack_latency: assert property (@(posedge clk_i) disable iff (rst_i)
        bus_req |=> wb_ack_o)
        else $error("request not acknowledged next cycle");

    a_unmapped_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        (bus_req && !wb_we_i && (wb_adr_i != adcc_pkg::ADDR_CSR) && (wb_adr_i != adcc_pkg::ADDR_RES_HI)
        && (wb_adr_i != adcc_pkg::ADDR_RES_LO)) |=> (wb_dat_o == 32'h00000000))
        else $error("unmapped read returned nonzero data");

    a_csr_read_layout: assert property (@(posedge clk_i) disable iff (rst_i)
        (bus_req && !wb_we_i && (wb_adr_i == adcc_pkg::ADDR_CSR))
        |=> (wb_dat_o[4:3] == 2'b00) && (wb_dat_o[7] == $past(st_reg.eoc)))
        else $error("control read returned wrong bits");

    a_tick_needs_run: assert property (@(posedge clk_i) disable iff (rst_i)
        !cv.run |=> !cv.tick)
        else $error("converter clock running while stopped");

    a_fast_tick: assert property (@(posedge clk_i) disable iff (rst_i)
        (cv.run && cv.speed && !cv.slow) |=> cv.tick)
        else $error("undivided converter clock missed a tick");

    a_half_gap: assert property (@(posedge clk_i) disable iff (rst_i)
        (cv.tick && !cv.slow && !cv.speed && cv.run) |=> !cv.tick)
        else $error("half-rate converter clock ticked twice in a row");

    a_half_period: assert property (@(posedge clk_i) disable iff (rst_i)
        (cv.tick && !cv.slow && !cv.speed && cv.run) ##1 (!cv.slow && !cv.speed && cv.run) |=> cv.tick)
        else $error("half-rate converter clock missed a tick");

    a_quarter_period: assert property (p_quarter_period)
        else $error("quarter-rate converter clock period wrong");

endmodule : adcc_top

// ===== testbench/adcc_analog_model.sv
// Analog side of the converter: per-channel input levels against the trial code
`timescale 1ns/1ps
module adcc_analog_model (
    input  wire logic             power_i,
    input  wire logic [9:0]       dac_code_i,
    input  wire logic [2:0]       channel_i,
    input  wire logic [6:0][10:0] level_i,
    output logic                  comparator_o
);
    // Level 400h stands for an input above the high reference
    always_comb begin
        if (!power_i || channel_i == 3'h7) begin
            comparator_o = 1'b0; // Unpowered comparator reads low
        end else begin
            comparator_o = ({1'b0, dac_code_i} <= level_i[channel_i]);
        end
    end
endmodule : adcc_analog_model

// ===== testbench/tb_top.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {
        logic [2:0]  ch;
        logic        speed;
        logic        slow;
        logic [10:0] level;
        logic [9:0]  exp;
    } adcc_row_t;
    logic             clk, rst, cyc, stb, we, halt, comp, pwr, sh;
    logic [3:0]       adr, sel;
    logic [31:0]      wdat, rdat;
    logic             ack;
    logic [9:0]       dac;
    logic [2:0]       chan;
    logic [6:0][10:0] level;
    logic [7:0]       q;
    int               fails, cmp_count, cycles, n, div;
    adcc_row_t rows [7] = '{
        '{3'h0, 1'b0, 1'b0, 11'h155, 10'h155}, '{3'h1, 1'b1, 1'b0, 11'h2AA, 10'h2AA},
        '{3'h2, 1'b0, 1'b1, 11'h400, 10'h3FF}, '{3'h3, 1'b1, 1'b1, 11'h000, 10'h000},
        '{3'h4, 1'b1, 1'b0, 11'h3FF, 10'h3FF}, '{3'h5, 1'b0, 1'b0, 11'h001, 10'h001},
        '{3'h6, 1'b1, 1'b0, 11'h27C, 10'h27C}};
    adcc_top DUT (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .halt_i(halt), .comparator_i(comp), .converter_power_on_o(pwr), .sample_hold_o(sh),
        .dac_code_o(dac), .input_channel_select_o(chan));
    adcc_analog_model analog (.power_i(pwr), .dac_code_i(dac), .channel_i(chan), .level_i(level),
        .comparator_o(comp));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic final_report;
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : final_report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Classic single cycle; held until ack is seen high
    task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [7:0] r);
        int k;
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'h1; wdat <= {24'h0, d};
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && k < 50);
        chk(k < 50, 1'b1); // Bus answers within bound
        r = rdat[7:0];
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask : wb
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] r;
        wb(1'b1, a, d, r);
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] r);
        wb(1'b0, a, 8'h00, r);
    endtask : rd
    // Poll the end flag, bounded by read count
    task automatic wait_eoc;
        int k;
        k = 0;
        do begin
            rd(adcc_pkg::ADDR_CSR, q);
            k++;
        end while (q[7] !== 1'b1 && k < 400);
        chk(q[7], 1'b1);
    endtask : wait_eoc
    // Full 10-bit read: low byte first, then high
    task automatic rd_result(input logic [9:0] exp);
        logic [7:0] lo;
        rd(adcc_pkg::ADDR_RES_LO, lo);
        rd(adcc_pkg::ADDR_RES_HI, q);
        chk(lo[7:0] & 8'hE7, {6'h00, exp[1:0]});
        chk(q, exp[9:2]);
        rd(adcc_pkg::ADDR_CSR, q);
        chk(q[7], 1'b0);
    endtask : rd_result
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            fails++;
            final_report();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; halt = 1'b0;
        adr = 4'h0; sel = 4'h0; wdat = 32'h0; fails = 0; cmp_count = 0; cycles = 0;
        for (int i = 0; i < 7; i++) level[i] = rows[i].level;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd(adcc_pkg::ADDR_CSR, q);
        chk(q, 8'h00);
        chk({pwr, chan}, 4'h0);
        rd(adcc_pkg::ADDR_RES_LO, q);
        chk(q, 8'h00);
        // Writable fields only; flag and reserved bits stay zero
        wr(adcc_pkg::ADDR_CSR, 8'hFF);
        rd(adcc_pkg::ADDR_CSR, q);
        chk(q, 8'h67);
        wr(adcc_pkg::ADDR_RES_LO, 8'hFF);
        rd(adcc_pkg::ADDR_RES_LO, q);
        chk(q, 8'h08);
        rd(4'hC, q);
        chk(q, 8'h00);
        for (int i = 0; i < 7; i++) begin
            div = rows[i].slow ? 4 : (rows[i].speed ? 1 : 2);
            wr(adcc_pkg::ADDR_CSR, 8'h00);
            rd(adcc_pkg::ADDR_RES_HI, q);
            wr(adcc_pkg::ADDR_RES_LO, {4'h0, rows[i].slow, 3'h0});
            wr(adcc_pkg::ADDR_CSR, {1'b0, rows[i].speed, 3'h4, rows[i].ch});
            chk({pwr, chan}, {1'b1, rows[i].ch});
            n = 0;
            while (dac === 10'h200 && n < 2000) begin @(posedge clk); n++; end
            while (dac !== 10'h200 && n < 2000) begin @(posedge clk); n++; end
            n = 0;
            while (dac === 10'h200 && n < 100) begin @(posedge clk); n++; end
            chk(n, 6 * div);
            wait_eoc();
            chk(q, {1'b1, rows[i].speed, 3'b100, rows[i].ch});
            rd_result(rows[i].exp);
        end
        // Results keep flowing unread; newest overwrites
        wait_eoc();
        level[6] <= 11'h0C3;
        repeat (200) @(posedge clk);
        rd(adcc_pkg::ADDR_RES_LO, q);
        rd(adcc_pkg::ADDR_CSR, q);
        chk(q[7], 1'b1);
        wr(adcc_pkg::ADDR_RES_HI, 8'hAA);
        rd_result(10'h0C3);
        // Halt drops power at once; settling before sampling resumes
        @(posedge clk);
        halt <= 1'b1;
        @(posedge clk);
        chk(pwr, 1'b0);
        rd(adcc_pkg::ADDR_RES_HI, q);
        repeat (300) @(posedge clk);
        rd(adcc_pkg::ADDR_CSR, q);
        chk(q, 8'h66);
        halt <= 1'b0;
        n = 0;
        repeat (95) begin
            @(posedge clk);
            if (sh === 1'b1) n++;
        end
        chk(n, 0);
        wait_eoc();
        rd_result(10'h0C3);
        // Power-off stops conversions
        wr(adcc_pkg::ADDR_CSR, 8'h06);
        rd(adcc_pkg::ADDR_RES_HI, q);
        chk(pwr, 1'b0);
        repeat (300) @(posedge clk);
        rd(adcc_pkg::ADDR_CSR, q);
        chk(q, 8'h06);
        final_report();
    end
endmodule : tb_top
